// ===== rtl/slp_pkg.sv
// slp_pkg: constants for the sleep-mode and clock-gating controller
// assumes an 8-bit register port with one-cycle read latency
package slp_pkg;
   // register offsets
   localparam logic [3:0] SLP_CTRL_ADDR   = 4'h0;
   localparam logic [3:0] SLP_PRGEN_ADDR  = 4'h1;
   localparam logic [3:0] SLP_PRPA_ADDR   = 4'h2;
   localparam logic [3:0] SLP_PRPC_ADDR   = 4'h4;
   localparam logic [3:0] SLP_PRPD_ADDR   = 4'h5;
   localparam logic [3:0] SLP_PRPE_ADDR   = 4'h6;
   localparam logic [3:0] SLP_PRPF_ADDR   = 4'h7;
   localparam logic [3:0] SLP_STATUS_ADDR = 4'h8;
   // control field layout
   localparam int         SLP_ARM_BIT     = 0;
   localparam int         SLP_MODE_LSB    = 1;
   localparam int         SLP_MODE_MSB    = 3;
   localparam logic [7:0] SLP_CTRL_MASK   = 8'h0F;
   // implemented stop bits per register
   localparam logic [7:0] SLP_PRGEN_MASK  = 8'h57;
   localparam logic [7:0] SLP_PRPA_MASK   = 8'h03;
   localparam logic [7:0] SLP_PRPC_MASK   = 8'h5F;
   localparam logic [7:0] SLP_PRPD_MASK   = 8'h19;
   localparam logic [7:0] SLP_PRPE_MASK   = 8'h51;
   localparam logic [7:0] SLP_PRPF_MASK   = 8'h11;
   localparam logic [7:0] SLP_RESET_VAL   = 8'h00;
   localparam int         SLP_NUM_PR      = 6;
   // mode codes
   localparam logic [2:0] SLP_IDLE_CODE                       = 3'h0;
   localparam logic [2:0] SLP_DEEP_HALT_CODE                  = 3'h2;
   localparam logic [2:0] SLP_COUNTER_KEPT_HALT_CODE          = 3'h3;
   localparam logic [2:0] SLP_OSCILLATOR_KEPT_HALT_CODE       = 3'h6;
   localparam logic [2:0] SLP_OSCILLATOR_COUNTER_KEPT_HALT_CODE = 3'h7;
   // timing
   localparam int         SLP_WAKE_HOLD_CYCLES = 4;
   localparam logic [2:0] SLP_WAKE_HOLD_LAST   = 3'(SLP_WAKE_HOLD_CYCLES - 1);
   localparam logic [7:0] SLP_OSC_START_DEFAULT = 8'h10;
   typedef enum logic [1:0] {SLP_ACTIVE, SLP_ASLEEP, SLP_OSC_WAIT, SLP_HOLD} slp_state_e;
endpackage : slp_pkg

// ===== rtl/slp_ctrl.sv
// slp_ctrl: sleep-mode sequencer, clock domain enables and peripheral clock stop
// assumes cpu raises sleep_instr for one cycle; wake sources are sync to sys_clk
`timescale 1ns/1ns
module slp_ctrl (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [7:0]  reg_rdata,
   // cpu side
   input  wire logic        sleep_instr,
   input  wire logic        nvm_busy,
   input  wire logic        debug_enabled,
   output logic             cpu_halt,
   output logic             wake_pulse,
   output logic             sleeping,
   // interrupt requests
   input  wire logic        any_irq,
   input  wire logic        two_wire_port_irq,
   input  wire logic        async_port_irq,
   input  wire logic        usb_resume_irq,
   input  wire logic        rtc_irq,
   // oscillators
   input  wire logic        rtc_enabled,
   input  wire logic        sys_osc_ready,
   input  wire logic [7:0]  osc_start_cycles,
   input  wire logic        ac_uses_vref,
   input  wire logic        wdt_enabled,
   input  wire logic        bod_fuse_enabled,
   // clock domain enables
   output logic             cpu_clk_en,
   output logic             nvm_clk_en,
   output logic             peripheral_clock_en,
   output logic             rtc_clk_en,
   output logic             sys_osc_en,
   output logic             rtc_osc_en,
   output logic [7:0]       prgen_clk_en,
   output logic [7:0]       prpa_clk_en,
   output logic [7:0]       prpc_clk_en,
   output logic [7:0]       prpd_clk_en,
   output logic [7:0]       prpe_clk_en,
   output logic [7:0]       prpf_clk_en,
   output logic [7:0]       prgen_access_block,
   output logic [7:0]       prpa_access_block,
   output logic [7:0]       prpc_access_block,
   output logic [7:0]       prpd_access_block,
   output logic [7:0]       prpe_access_block,
   output logic [7:0]       prpf_access_block,
   // analog and misc
   output logic             adc_enable,
   output logic             adc_extended_conv,
   output logic             ac_enable,
   output logic             vref_enable,
   output logic             input_buffer_en,
   output logic             wdt_active,
   output logic             bod_active
);
   import slp_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   slp_state_e  state_reg;
   logic [2:0]  low_power_mode_select;
   logic        sleep_arm_bit;
   logic [7:0]  peripheral_clock_stop_bits [SLP_NUM_PR];
   logic [2:0]  hold_cnt_reg;
   logic [7:0]  osc_cnt_reg;
   logic        adc_was_off_reg;

   localparam logic [3:0] PR_ADDRS [SLP_NUM_PR] = '{SLP_PRGEN_ADDR, SLP_PRPA_ADDR,
      SLP_PRPC_ADDR, SLP_PRPD_ADDR, SLP_PRPE_ADDR, SLP_PRPF_ADDR};
   localparam logic [7:0] PR_MASKS [SLP_NUM_PR] = '{SLP_PRGEN_MASK, SLP_PRPA_MASK,
      SLP_PRPC_MASK, SLP_PRPD_MASK, SLP_PRPE_MASK, SLP_PRPF_MASK};

   // mode decode, reused for entry and clock plan
   function automatic logic mode_valid(input logic [2:0] m);
      mode_valid = (m == SLP_IDLE_CODE) || (m == SLP_DEEP_HALT_CODE) ||
                   (m == SLP_COUNTER_KEPT_HALT_CODE) ||
                   (m == SLP_OSCILLATOR_KEPT_HALT_CODE) ||
                   (m == SLP_OSCILLATOR_COUNTER_KEPT_HALT_CODE);
   endfunction : mode_valid

   function automatic logic mode_keeps_rtc(input logic [2:0] m);
      mode_keeps_rtc = (m == SLP_IDLE_CODE) || (m == SLP_COUNTER_KEPT_HALT_CODE) ||
                       (m == SLP_OSCILLATOR_COUNTER_KEPT_HALT_CODE);
   endfunction : mode_keeps_rtc

   function automatic logic mode_keeps_osc(input logic [2:0] m);
      mode_keeps_osc = (m == SLP_IDLE_CODE) || (m == SLP_OSCILLATOR_KEPT_HALT_CODE) ||
                       (m == SLP_OSCILLATOR_COUNTER_KEPT_HALT_CODE);
   endfunction : mode_keeps_osc

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         low_power_mode_select <= 3'h0;
         sleep_arm_bit         <= 1'b0;
      end else if (reg_write && reg_addr == SLP_CTRL_ADDR) begin
         low_power_mode_select <= reg_wdata[SLP_MODE_MSB:SLP_MODE_LSB];
         sleep_arm_bit         <= reg_wdata[SLP_ARM_BIT];
      end
   end

   // ------------------------------------------------------------
   // clock stop registers
   // ------------------------------------------------------------
   generate
      for (genvar i = 0; i < SLP_NUM_PR; i++) begin : g_pr
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               peripheral_clock_stop_bits[i] <= SLP_RESET_VAL;
            end else if (reg_write && reg_addr == PR_ADDRS[i]) begin
               peripheral_clock_stop_bits[i] <= reg_wdata & PR_MASKS[i];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // sleep sequencer
   // ------------------------------------------------------------
   logic wake_req;
   logic in_idle;
   assign in_idle = (low_power_mode_select == SLP_IDLE_CODE);

   always_comb begin
      wake_req = 1'b0;
      if (in_idle) begin
         wake_req = any_irq;
      end else begin
         wake_req = two_wire_port_irq || async_port_irq || usb_resume_irq;
         if (mode_keeps_rtc(low_power_mode_select) && rtc_enabled) begin
            wake_req = wake_req || rtc_irq;
         end
      end
   end

   // synchronous reset aborts sleep to active
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_reg    <= SLP_ACTIVE;
         hold_cnt_reg <= 3'h0;
         osc_cnt_reg  <= 8'h00;
         wake_pulse   <= 1'b0;
      end else begin
         wake_pulse <= 1'b0;
         case (state_reg)
            SLP_ACTIVE: begin
               if (sleep_instr && sleep_arm_bit && mode_valid(low_power_mode_select)) begin
                  state_reg <= SLP_ASLEEP;
               end
            end
            SLP_ASLEEP: begin
               if (wake_req) begin
                  osc_cnt_reg <= osc_start_cycles;
                  if (mode_keeps_osc(low_power_mode_select) || debug_enabled) begin
                     state_reg    <= SLP_HOLD;
                     hold_cnt_reg <= 3'h0;
                  end else begin
                     state_reg <= SLP_OSC_WAIT;
                  end
               end
            end
            SLP_OSC_WAIT: begin
               if (osc_cnt_reg != 8'h00) begin
                  osc_cnt_reg <= osc_cnt_reg - 8'h01;
               end else if (sys_osc_ready) begin
                  state_reg    <= SLP_HOLD;
                  hold_cnt_reg <= 3'h0;
               end
            end
            SLP_HOLD: begin
               if (hold_cnt_reg == SLP_WAKE_HOLD_LAST) begin
                  state_reg <= SLP_ACTIVE;
                  wake_pulse <= 1'b1;
               end else begin
                  hold_cnt_reg <= hold_cnt_reg + 3'h1;
               end
            end
            default: state_reg <= SLP_ACTIVE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // clock plan, registered
   // ------------------------------------------------------------
   logic        asleep_n;
   logic        periph_dom;
   logic        rtc_dom;
   logic        osc_dom;
   logic        entering;
   logic        will_sleep;
   assign entering   = (state_reg == SLP_ACTIVE) && sleep_instr && sleep_arm_bit &&
                       mode_valid(low_power_mode_select);
   assign will_sleep = entering || (state_reg == SLP_ASLEEP && !wake_req) ||
                       (state_reg == SLP_OSC_WAIT);
   assign asleep_n   = !will_sleep;
   assign periph_dom = asleep_n || in_idle;
   // counter domain kept in save modes
   assign rtc_dom    = asleep_n || (mode_keeps_rtc(low_power_mode_select) && rtc_enabled);
   assign osc_dom    = asleep_n || mode_keeps_osc(low_power_mode_select) || debug_enabled ||
                       (state_reg == SLP_OSC_WAIT);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cpu_clk_en          <= 1'b1;
         nvm_clk_en          <= 1'b1;
         peripheral_clock_en <= 1'b1;
         rtc_clk_en          <= 1'b1;
         sys_osc_en          <= 1'b1;
         rtc_osc_en          <= 1'b1;
         cpu_halt            <= 1'b0;
         sleeping            <= 1'b0;
         input_buffer_en     <= 1'b1;
      end else begin
         cpu_clk_en          <= (state_reg == SLP_ACTIVE) && !entering;
         cpu_halt            <= (state_reg != SLP_ACTIVE) || entering;
         sleeping            <= will_sleep;
         nvm_clk_en          <= asleep_n || nvm_busy;
         peripheral_clock_en <= periph_dom;
         rtc_clk_en          <= rtc_dom;
         rtc_osc_en          <= rtc_dom;
         sys_osc_en          <= osc_dom;
         input_buffer_en     <= periph_dom;
      end
   end

   // state held, so resume is exact
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         prgen_clk_en       <= 8'hFF;
         prpa_clk_en        <= 8'hFF;
         prpc_clk_en        <= 8'hFF;
         prpd_clk_en        <= 8'hFF;
         prpe_clk_en        <= 8'hFF;
         prpf_clk_en        <= 8'hFF;
         prgen_access_block <= 8'h00;
         prpa_access_block  <= 8'h00;
         prpc_access_block  <= 8'h00;
         prpd_access_block  <= 8'h00;
         prpe_access_block  <= 8'h00;
         prpf_access_block  <= 8'h00;
      end else begin
         prgen_clk_en       <= {8{periph_dom}} & ~peripheral_clock_stop_bits[0];
         prpa_clk_en        <= {8{periph_dom}} & ~peripheral_clock_stop_bits[1];
         prpc_clk_en        <= {8{periph_dom}} & ~peripheral_clock_stop_bits[2];
         prpd_clk_en        <= {8{periph_dom}} & ~peripheral_clock_stop_bits[3];
         prpe_clk_en        <= {8{periph_dom}} & ~peripheral_clock_stop_bits[4];
         prpf_clk_en        <= {8{periph_dom}} & ~peripheral_clock_stop_bits[5];
         prgen_access_block <= peripheral_clock_stop_bits[0];
         prpa_access_block  <= peripheral_clock_stop_bits[1];
         prpc_access_block  <= peripheral_clock_stop_bits[2];
         prpd_access_block  <= peripheral_clock_stop_bits[3];
         prpe_access_block  <= peripheral_clock_stop_bits[4];
         prpf_access_block  <= peripheral_clock_stop_bits[5];
      end
   end

   // ------------------------------------------------------------
   // analog, watchdog, brownout
   // ------------------------------------------------------------
   logic adc_on_next;
   assign adc_on_next = asleep_n || in_idle;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         adc_enable        <= 1'b1;
         ac_enable         <= 1'b1;
         vref_enable       <= 1'b0;
         adc_was_off_reg   <= 1'b0;
         adc_extended_conv <= 1'b0;
         wdt_active        <= 1'b0;
         bod_active        <= 1'b0;
      end else begin
         adc_enable <= adc_on_next;
         if (!adc_on_next) begin
            adc_was_off_reg <= 1'b1;
         end else if (adc_was_off_reg) begin
            adc_was_off_reg <= 1'b0;
         end
         adc_extended_conv <= adc_on_next && adc_was_off_reg;
         ac_enable   <= adc_on_next;
         vref_enable <= ac_uses_vref;
         wdt_active  <= wdt_enabled;
         bod_active  <= bod_fuse_enabled;
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         if (reg_addr == SLP_CTRL_ADDR) begin
            reg_rdata <= {4'h0, low_power_mode_select, sleep_arm_bit} & SLP_CTRL_MASK;
         end else if (reg_addr == SLP_PRGEN_ADDR) begin
            reg_rdata <= peripheral_clock_stop_bits[0];
         end else if (reg_addr == SLP_PRPA_ADDR) begin
            reg_rdata <= peripheral_clock_stop_bits[1];
         end else if (reg_addr == SLP_PRPC_ADDR) begin
            reg_rdata <= peripheral_clock_stop_bits[2];
         end else if (reg_addr == SLP_PRPD_ADDR) begin
            reg_rdata <= peripheral_clock_stop_bits[3];
         end else if (reg_addr == SLP_PRPE_ADDR) begin
            reg_rdata <= peripheral_clock_stop_bits[4];
         end else if (reg_addr == SLP_PRPF_ADDR) begin
            reg_rdata <= peripheral_clock_stop_bits[5];
         end else if (reg_addr == SLP_STATUS_ADDR) begin
            reg_rdata <= {6'h00, state_reg};
         end else begin
            reg_rdata <= 8'h00;
         end
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule : slp_ctrl

// ===== dv/slp_chk.sv
// slp_chk: assertions on the sleep controller ports
// assumes sync active-high reset on sys_clk
`timescale 1ns/1ns
module slp_chk import slp_pkg::*; (
   // clock, reset and register port
   input wire logic       sys_clk,
   input wire logic       reset,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   // cpu side
   input wire logic       sleep_instr,
   input wire logic       debug_enabled,
   input wire logic       cpu_halt,
   input wire logic       wake_pulse,
   input wire logic       sleeping,
   // enables
   input wire logic       cpu_clk_en,
   input wire logic       peripheral_clock_en,
   input wire logic       sys_osc_en,
   input wire logic       adc_enable,
   input wire logic       ac_enable,
   input wire logic [7:0] prpc_clk_en,
   input wire logic [7:0] prpc_access_block
);
   logic [3:0] ctrl_q;
   logic       idle;
   logic       okeep;
   logic       rsv;
   logic       go;
   // ---------------
   // control shadow
   // ---------------
   always_ff @(posedge sys_clk) begin
      if (reset)
         ctrl_q <= 4'h0;
      else if (reg_write && reg_addr == SLP_CTRL_ADDR)
         ctrl_q <= reg_wdata[3:0];
   end
   assign idle  = ctrl_q[3:1] == SLP_IDLE_CODE;
   assign okeep = idle || ctrl_q[3] || debug_enabled;
   assign rsv   = ctrl_q[3:1] inside {3'h1, 3'h4, 3'h5};
   assign go    = sleep_instr && !cpu_halt && ctrl_q[0] && !rsv;
   // ---------------
   // properties
   // ---------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_sleep_entry: assert property (go |=> cpu_halt && sleeping)
      else $error("sleep not entered");
   a_unarmed_ignored: assert property (
      sleep_instr && !cpu_halt && !ctrl_q[0] |=> !sleeping)
      else $error("unarmed sleep taken");
   a_reserved_ignored: assert property (
      sleep_instr && !cpu_halt && rsv |=> !cpu_halt)
      else $error("reserved mode taken");
   a_domain_stop: assert property (
      go |=> !cpu_clk_en && peripheral_clock_en == $past(idle))
      else $error("domain enables wrong");
   a_osc_kept: assert property (go |=> sys_osc_en == $past(okeep))
      else $error("oscillator enable wrong");
   a_analog_off: assert property (
      go |=> adc_enable == $past(idle) && ac_enable == $past(idle))
      else $error("analog enables wrong");
   a_stop_gate: assert property (
      prpc_clk_en == ({8{peripheral_clock_en}} & ~prpc_access_block))
      else $error("peripheral enable wrong");
   a_absent_bits: assert property ((prpc_access_block & ~SLP_PRPC_MASK) == 8'h00)
      else $error("absent stop bit set");
   a_wake_release: assert property (wake_pulse |=> !cpu_halt && !wake_pulse)
      else $error("halt not released");
endmodule : slp_chk

bind slp_ctrl slp_chk i_slp_chk (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_write,
   .sleep_instr, .debug_enabled, .cpu_halt, .wake_pulse, .sleeping, .cpu_clk_en,
   .peripheral_clock_en, .sys_osc_en, .adc_enable, .ac_enable, .prpc_clk_en,
   .prpc_access_block);

// ===== dv/slp_cpu_model.sv
// slp_cpu_model: cpu, interrupt controller and oscillator stand-in
// assumes the bench pulses sleep_req and irq_set for one cycle
`timescale 1ns/1ns
module slp_cpu_model #(
   parameter int OSC_READY_CYCLES = 3
) (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       reset,
   // bench commands
   input wire logic       sleep_req,
   input wire logic [3:0] irq_set,
   // controller side
   input wire logic       wake_pulse,
   input wire logic       sys_osc_en,
   output logic           sleep_instr,
   output logic           any_irq,
   output logic           rtc_irq,
   output logic           two_wire_port_irq,
   output logic           async_port_irq,
   output logic           usb_resume_irq,
   output logic           sys_osc_ready
);
   logic [3:0] irq_reg;
   logic [7:0] osc_cnt;
   always_ff @(posedge sys_clk) sleep_instr <= sleep_req && !reset;
   // service routine clears its request on wake
   always_ff @(posedge sys_clk) begin
      if (reset || wake_pulse)
         irq_reg <= 4'h0;
      else
         irq_reg <= irq_reg | irq_set;
   end
   assign {usb_resume_irq, async_port_irq, two_wire_port_irq, rtc_irq} = irq_reg;
   assign any_irq = |irq_reg;
   // oscillator settles some cycles after enable
   always_ff @(posedge sys_clk) begin
      if (reset || !sys_osc_en)
         osc_cnt <= 8'h00;
      else if (osc_cnt != 8'hFF)
         osc_cnt <= osc_cnt + 8'h01;
   end
   assign sys_osc_ready = osc_cnt >= 8'(OSC_READY_CYCLES);
endmodule : slp_cpu_model

// ===== dv/tb_sleep_mode_clock_gating.sv
// tb_sleep_mode_clock_gating: register and sleep sequence tests
// assumes slp_ctrl with sync active-high reset on a 100 MHz clock
`timescale 1ns/1ns
module tb_sleep_mode_clock_gating;
   import slp_pkg::*;
   localparam logic [7:0] OSC_START = 8'h08;
   localparam logic [2:0] MT [6] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7, 3'h2};
   localparam logic [3:0] ST [6] = '{4'h1, 4'h2, 4'h2, 4'h4, 4'h1, 4'h8};
   localparam logic [3:0] PA [6] = '{SLP_PRGEN_ADDR, SLP_PRPA_ADDR, SLP_PRPC_ADDR,
      SLP_PRPD_ADDR, SLP_PRPE_ADDR, SLP_PRPF_ADDR};
   localparam logic [7:0] PM [6] = '{SLP_PRGEN_MASK, SLP_PRPA_MASK, SLP_PRPC_MASK,
      SLP_PRPD_MASK, SLP_PRPE_MASK, SLP_PRPF_MASK};
   localparam logic [7:0] RV [4] = '{8'h00, 8'h03, 8'h09, 8'h0B};
   logic       sys_clk, reset, reg_write, reg_read, sleep_req, debug_enabled;
   logic       ac_uses_vref, cpu_halt, wake_pulse, sleeping, cpu_clk_en, rtc_clk_en;
   logic       peripheral_clock_en, sys_osc_en, adc_enable, adc_extended_conv, ac_enable;
   logic       vref_enable, input_buffer_en, wdt_active, bod_active, sleep_instr, any_irq;
   logic       rtc_irq, two_wire_port_irq, async_port_irq, usb_resume_irq, sys_osc_ready;
   logic       ext_seen, idle, okeep, nvm_busy, rtc_enabled, wdt_enabled, bod_fuse_enabled;
   logic       nvm_clk_en, rtc_osc_en;
   logic [2:0] m;
   logic [3:0] reg_addr, irq_set;
   logic [7:0] reg_wdata, reg_rdata, pe [6], pb [6];
   int         errors, total_checks, nh, no;

   slp_ctrl i_slp_ctrl (
      .sys_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .sleep_instr, .nvm_busy, .debug_enabled, .cpu_halt, .wake_pulse, .sleeping,
      .any_irq, .two_wire_port_irq, .async_port_irq, .usb_resume_irq, .rtc_irq,
      .rtc_enabled, .sys_osc_ready, .osc_start_cycles(OSC_START), .ac_uses_vref,
      .wdt_enabled, .bod_fuse_enabled, .cpu_clk_en, .nvm_clk_en,
      .peripheral_clock_en, .rtc_clk_en, .sys_osc_en, .rtc_osc_en, .prgen_clk_en(pe[0]),
      .prpa_clk_en(pe[1]), .prpc_clk_en(pe[2]), .prpd_clk_en(pe[3]), .prpe_clk_en(pe[4]),
      .prpf_clk_en(pe[5]), .prgen_access_block(pb[0]), .prpa_access_block(pb[1]),
      .prpc_access_block(pb[2]), .prpd_access_block(pb[3]), .prpe_access_block(pb[4]),
      .prpf_access_block(pb[5]), .adc_enable,
      .adc_extended_conv, .ac_enable, .vref_enable, .input_buffer_en, .wdt_active,
      .bod_active);
   slp_cpu_model i_slp_cpu_model (
      .sys_clk, .reset, .sleep_req, .irq_set, .wake_pulse, .sys_osc_en, .sleep_instr,
      .any_irq, .rtc_irq, .two_wire_port_irq, .async_port_irq, .usb_resume_irq,
      .sys_osc_ready);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(negedge sys_clk) if (adc_extended_conv) ext_seen = 1'b1;
   // ---------------
   // access tasks
   // ---------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      @(negedge sys_clk);
      check(reg_rdata, exp);
   endtask : rd
   task automatic sleep_now;
      @(posedge sys_clk);
      sleep_req <= 1'b1;
      @(posedge sys_clk);
      sleep_req <= 1'b0;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : sleep_now
   // raise a wake source and poll status until active, counting states
   task automatic wake_count(input logic [3:0] src, output int n_hold, output int n_osc);
      int   i;
      logic done;
      n_hold = 0;
      n_osc  = 0;
      i      = 0;
      done   = 1'b0;
      @(posedge sys_clk);
      irq_set  <= src;
      reg_addr <= SLP_STATUS_ADDR;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      irq_set <= 4'h0;
      while (!done && i < 500) begin
         @(negedge sys_clk);
         n_hold += int'(reg_rdata[1:0] == 2'h3);
         n_osc  += int'(reg_rdata[1:0] == 2'h2);
         done = (reg_rdata == 8'h00) && (n_hold > 0);
         i++;
         @(posedge sys_clk);
      end
      reg_read <= 1'b0;
   endtask : wake_count
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict

   initial begin
      #200000;
      errors++;
      print_verdict();
   end
   // ---------------
   // tests
   // ---------------
   initial begin
      {reset, reg_write, reg_read, sleep_req, debug_enabled, ac_uses_vref} = 6'h20;
      {reg_addr, irq_set, reg_wdata, ext_seen, errors, total_checks} = '0;
      {nvm_busy, rtc_enabled, wdt_enabled, bod_fuse_enabled} = 4'h0;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      rd(SLP_CTRL_ADDR, 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr(PA[i], 8'hFF);
         rd(PA[i], PM[i]);
         check(pb[i], PM[i]);
         check(pe[i], ~PM[i]);
      end
      check(pe[2], ~SLP_PRPC_MASK);
      check(pb[2], SLP_PRPC_MASK);
      for (int i = 0; i < 6; i++) wr(PA[i], 8'h00);
      repeat (2) @(negedge sys_clk);
      for (int i = 0; i < 6; i++) check(pe[i], 8'hFF);
      wr(4'h3, 8'hFF);
      rd(4'h3, 8'h00);
      $display("stop bit test done");
      for (int j = 0; j < 4; j++) begin
         wr(SLP_CTRL_ADDR, RV[j]);
         sleep_now();
         check(8'({sleeping, cpu_halt}), 8'h00);
      end
      $display("refusal test done");
      for (int i = 0; i < 6; i++) begin
         m     = MT[i];
         idle  = (m == 3'h0);
         okeep = idle || m[2] || (i == 5);
         @(posedge sys_clk);
         debug_enabled    <= (i == 5);
         ac_uses_vref     <= i[0];
         nvm_busy         <= i[1];
         rtc_enabled      <= (i != 2);
         wdt_enabled      <= !i[0];
         bod_fuse_enabled <= i[1];
         ext_seen = 1'b0;
         wr(SLP_CTRL_ADDR, {4'h0, m, 1'b1});
         sleep_now();
         check(8'({sleeping, cpu_halt, cpu_clk_en}), 8'h06);
         check(8'(peripheral_clock_en), 8'(idle));
         check(8'(input_buffer_en), 8'(idle));
         check(8'({adc_enable, ac_enable}), 8'({2{idle}}));
         check(8'(vref_enable), 8'(i[0]));
         check(8'(sys_osc_en), 8'(okeep));
         check(8'({rtc_clk_en, rtc_osc_en}), 8'({2{idle || (m[0] && i != 2)}}));
         check(8'(nvm_clk_en), 8'(i[1]));
         check(8'({wdt_active, bod_active}), 8'({!i[0], i[1]}));
         if (!(idle || m[0]) || i == 2) begin
            @(posedge sys_clk);
            irq_set <= 4'h1;
            @(posedge sys_clk);
            irq_set <= 4'h0;
            repeat (20) @(negedge sys_clk);
            check(8'(sleeping), 8'h01);
         end
         wake_count(ST[i], nh, no);
         check(8'(nh), 8'h04);
         check(8'(no >= OSC_START), 8'(!okeep));
         @(negedge sys_clk);
         check(8'({cpu_halt, ext_seen}), 8'({1'b0, !idle}));
         rd(SLP_CTRL_ADDR, {4'h0, m, 1'b1});
      end
      $display("mode test done");
      wr(SLP_CTRL_ADDR, {4'h0, SLP_DEEP_HALT_CODE, 1'b1});
      sleep_now();
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      @(negedge sys_clk);
      check(8'({cpu_halt, sleeping}), 8'h00);
      rd(SLP_STATUS_ADDR, 8'h00);
      rd(SLP_CTRL_ADDR, 8'h00);
      $display("reset test done");
      print_verdict();
   end
endmodule : tb_sleep_mode_clock_gating
